// ===== core/fmdt_media_reg.sv
// Media and drive-type register with APB access and two layouts.
//
// Functional notes
// R1: Configuration mode bit picks legacy layout at 0, enhanced layout at 1.
// R2: Legacy mode assigns one logical drive to tape support of the separator.
// R3: Drives not assigned to tape are handled as floppy drives.
// R4: Legacy reads leave bits 7 to 2 undriven; only two low bits return.
// R5: Enhanced mode gives meaning to all eight register bits.
// R6: Reset clears low bits; enhanced sets bits 5,4, keeps bits 7,6; the code clears bits 7,6 to zero at reset.
// R7: Tape code 01, 10, 11 selects logical drive 1, 2, 3.
// R8: Drive 0 is never a tape drive; code 00 means none selected.
// R9: Reads return stored low bits; writes update the writable bits.
`timescale 1ns/1ns
`include "fmdt_cfg.svh"
module fmdt_media_reg
  import fmdt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [1:0] densitySense,
  input wire logic [1:0] identSense,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] readDataOe,
  output logic [3:0] tapeDrive,
  output logic [3:0] floppyDrive,
  output logic [1:0] exchange,
  output logic enhancedMode
);
  fmdt_media_t media_reg, media_next;
  logic [7:0] config_reg, config_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [7:0] oe_reg, oe_next;
  fmdt_roles_t roles_reg, roles_next;
  fmdt_roles_t rolesDec;
  fmdt_mode_t mode;
  logic access;

  // Register index decoding shared by read and write paths.
  function automatic logic is_addr(input logic [11:0] a,
                                   input logic [11:0] off);
    is_addr = (a == off);
  endfunction

  assign mode = config_reg[`FMDT_CFG_MODE_BIT] ? FMDT_ENHANCED
                                               : FMDT_LEGACY; // R1
  assign access = psel && penable && !pready_reg;

  fmdt_tape_decode u_decode (
    .tapeSel(media_reg.tapeSel),
    .roles(rolesDec)
  );

  // Next-state logic: with clkEn high, every access completes one cycle after the access
  // phase opens, so pready is a single registered pulse.
  always_comb begin
    media_next = media_reg;
    config_next = config_reg;
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    oe_next = oe_reg;
    roles_next = (mode == FMDT_LEGACY) ? rolesDec
                 : '{tapeDrive: 4'h0, floppyDrive: 4'hf}; // R2
    // Sense inputs track live so enhanced reads show current media.
    if (mode == FMDT_ENHANCED) begin
      media_next.density = densitySense; // R5
      media_next.ident = identSense; // R5
    end
    if (access) begin
      pready_next = 1'b1;
      if (is_addr(paddr, `FMDT_OFF_MEDIA)) begin
        if (pwrite) begin
          if (pstrb[0]) begin
            media_next.tapeSel = pwdata[`FMDT_TAPE_LSB +: 2]; // R9
            if (mode == FMDT_ENHANCED) begin
              media_next.exchange = pwdata[`FMDT_XCHG_LSB +: 2]; // R9
            end
          end
        end else begin
          prdata_next = 32'h0;
          prdata_next[1:0] = media_reg.tapeSel; // R9
          if (mode == FMDT_ENHANCED) begin
            prdata_next[7:0] = media_reg; // R5
            oe_next = 8'h00;
          end else begin
            oe_next = 8'hfc; // R4
          end
        end
      end else if (is_addr(paddr, `FMDT_OFF_CONFIG)) begin
        if (pwrite) begin
          if (pstrb[0]) begin
            config_next = pwdata[7:0];
            // Entering enhanced layout loads its reset default for the exchange bits.
            if (pwdata[`FMDT_CFG_MODE_BIT] &&
                !config_reg[`FMDT_CFG_MODE_BIT]) begin
              media_next.exchange = `FMDT_RST_XCHG; // R6
            end
          end
        end else begin
          prdata_next = {24'h0, config_reg};
          oe_next = 8'h00;
        end
      end else if (is_addr(paddr, `FMDT_OFF_STATUS) && !pwrite) begin
        prdata_next = {24'h0, roles_reg.tapeDrive, roles_reg.floppyDrive};
        oe_next = 8'h00;
      end else begin
        // Unmapped offsets, and writes to the status word, report an error.
        pslverr_next = 1'b1;
        prdata_next = 32'h0;
        oe_next = 8'h00;
      end
    end
  end

  // Registers only; reset gives cleared low bits and set ident bits, while
  // density bits carry no reset meaning and simply start at zero.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      media_reg.tapeSel <= `FMDT_RST_LOW2; // R6
      media_reg.exchange <= `FMDT_RST_XCHG; // R6
      media_reg.ident <= `FMDT_RST_IDENT; // R6
      media_reg.density <= 2'h0;
      config_reg <= `FMDT_RST_CONFIG;
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      oe_reg <= 8'h00;
      roles_reg <= '{tapeDrive: 4'h0, floppyDrive: 4'hf};
    end else if (clkEn) begin
      media_reg <= media_next;
      config_reg <= config_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      oe_reg <= oe_next;
      roles_reg <= roles_next;
    end
  end

  // Outputs come straight from flip-flops.
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign readDataOe = oe_reg;
  assign tapeDrive = roles_reg.tapeDrive;
  assign floppyDrive = roles_reg.floppyDrive;
  assign exchange = media_reg.exchange;
  assign enhancedMode = config_reg[`FMDT_CFG_MODE_BIT];
endmodule

// ===== include/fmdt_cfg.svh
// Offsets, field positions, reset values and mode figures of the media register.
`ifndef FMDT_CFG_SVH
`define FMDT_CFG_SVH
`define FMDT_OFF_MEDIA 12'h000
`define FMDT_OFF_CONFIG 12'h004
`define FMDT_OFF_STATUS 12'h008
`define FMDT_CFG_MODE_BIT 6
`define FMDT_TAPE_LSB 0
`define FMDT_XCHG_LSB 2
`define FMDT_IDENT_LSB 4
`define FMDT_DENS_LSB 6
`define FMDT_RST_LOW2 2'h0
`define FMDT_RST_XCHG 2'h0
`define FMDT_RST_IDENT 2'h3
`define FMDT_RST_CONFIG 8'h00
`define FMDT_NO_TAPE 2'h0
`endif

// ===== include/fmdt_pkg.sv
// Types shared by the media and drive-type register block.
package fmdt_pkg;
  typedef enum logic {
    FMDT_LEGACY,
    FMDT_ENHANCED
  } fmdt_mode_t;
  typedef struct packed {
    logic [1:0] density;
    logic [1:0] ident;
    logic [1:0] exchange;
    logic [1:0] tapeSel;
  } fmdt_media_t;
  typedef struct packed {
    logic [3:0] tapeDrive;
    logic [3:0] floppyDrive;
  } fmdt_roles_t;
endpackage

// ===== core/fmdt_tape_decode.sv
// Decoder from tape select code to per-drive tape and floppy roles.
`timescale 1ns/1ns
module fmdt_tape_decode
  import fmdt_pkg::*;
(
  input wire logic [1:0] tapeSel,
  output fmdt_roles_t roles
);
  // Code 00 selects no tape drive, so drive 0 always stays a floppy.
  always_comb begin
    roles.tapeDrive = 4'h0;
    if (tapeSel != `FMDT_NO_TAPE) begin // R8
      roles.tapeDrive[tapeSel] = 1'b1; // R7
    end
    roles.floppyDrive = ~roles.tapeDrive; // R3
  end
endmodule

// ===== verification/fmdt_checker.sv
// Port checks for the media and drive-type register.
`timescale 1ns/1ns
module fmdt_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] readDataOe,
  input wire logic [3:0] tapeDrive,
  input wire logic [3:0] floppyDrive,
  input wire logic enhancedMode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Roles settle a cycle after a mode change, so guards look back.
  chk_tape_onehot: assert property ($onehot0(tapeDrive) && !tapeDrive[0])
    else $error("bad tape role");
  chk_floppy_rest: assert property (!enhancedMode && $past(!enhancedMode) |->
    floppyDrive == ~tapeDrive) else $error("bad floppy role");
  chk_enh_roles: assert property (enhancedMode [*2] |->
    tapeDrive == 4'h0 && floppyDrive == 4'hf) else $error("bad enh roles");
  chk_ready_time: assert property (psel && penable && !pready |=> pready)
    else $error("late ready");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("long ready");
  chk_legacy_float: assert property (pready && !pwrite && paddr == 12'h000
    && !enhancedMode |-> readDataOe == 8'hfc) else $error("bad legacy oe");
  chk_enh_drive: assert property (pready && !pwrite && enhancedMode
    |-> readDataOe == 8'h00) else $error("bad enh oe");
  chk_unmapped_err: assert property (pready && paddr > 12'h008 |-> pslverr)
    else $error("no error");
endmodule
bind fmdt_media_reg fmdt_checker i_chk (.*);

// ===== verification/fmdt_media_reg_bench.sv
// Self-checking bench for the media and drive-type register.
`timescale 1ns/1ns
module fmdt_media_reg_bench;
  logic ref_clk = 0, rst = 1, clkEn = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [3:0] pstrb = 4'hf, tapeDrive, floppyDrive;
  logic [1:0] densitySense = 0, identSense = 0, exchange;
  logic pready, pslverr, enhancedMode;
  logic [7:0] readDataOe, expQ[$];
  int err_count = 0, n_checks = 0, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  fmdt_media_reg i_dut (.*);
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Request is held until pready is seen high at a rising edge.
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    // One idle edge keeps back-to-back calls from driving psel twice.
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk) penable <= 1;
    @(posedge ref_clk iff pready === 1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(logic [11:0] a, logic [7:0] e);
    expQ.push_back(e);
    apb(0, a, 0);
  endtask
  // Read results are matched against the oldest note; hangs are cut here.
  always @(posedge ref_clk) begin
    cyc++;
    if (pready === 1 && pwrite === 0 && expQ.size() > 0)
      chk("prdata", expQ.pop_front(), prdata[7:0]);
    if (cyc > 2000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    void'($urandom(52));
    repeat (16) @(posedge ref_clk);
    rst <= 0;
    @(posedge ref_clk);
    rd(12'h000, 8'h00);
    for (int i = 0; i < 4; i++) begin
      apb(1, 12'h000, ($urandom() << 2) | i);
      rd(12'h000, i);
      chk("tape", (i == 0) ? 8'h0 : 8'h1 << i, tapeDrive);
      chk("floppy", (i == 0) ? 8'hf : 8'hf ^ 8'h1 << i, floppyDrive);
    end
    densitySense <= $urandom();
    identSense <= $urandom();
    apb(1, 12'h004, 32'h40);
    apb(1, 12'h000, 32'hf6);
    rd(12'h000, {densitySense, identSense, 4'h6});
    chk("exchange", 8'h1, exchange);
    chk("mode", 8'h1, enhancedMode);
    apb(1, 12'h004, 32'h0);
    rd(12'h000, 8'h02);
    rd(12'h008, 8'h4b);
    pstrb <= 4'he;
    apb(1, 12'h000, 32'h3);
    pstrb <= 4'hf;
    rd(12'h000, 8'h02);
    apb(1, 12'h00c, 32'h0);
    final_report();
  end
endmodule
